// ===== verilog/omr_pkg.sv
package omr_pkg;
    // Register map; printed offsets are not multiples of four, so they are indices
    localparam logic [7:0] STATUS_PIN_MUTE_CTRL_IDX = 8'h17;
    localparam logic [7:0] DIVIDER_DYNAMIC_DELAY_CTRL_IDX = 8'h18;
    localparam logic [7:0] REFERENCE_DETECT_CTRL_IDX = 8'h19;
    localparam logic [7:0] CLK_SRC_STATUS_IDX = 8'h1a;
    localparam logic [9:0] STATUS_PIN_MUTE_CTRL_ADDR = 10'h05c;
    localparam logic [9:0] DIVIDER_DYNAMIC_DELAY_CTRL_ADDR = 10'h060;
    localparam logic [9:0] REFERENCE_DETECT_CTRL_ADDR = 10'h064;
    localparam logic [9:0] CLK_SRC_STATUS_ADDR = 10'h068;
    // Field positions
    localparam int FIRST_AUTOMUTE_BIT = 0;
    localparam int SECOND_AUTOMUTE_BIT = 1;
    localparam int DETECT_METHOD_LSB = 6;
    localparam int DIVIDER_COUNT = 6;
    localparam int DIVIDE_MARGIN_MIN = 8;
    // Reset values and response codes
    localparam logic [1:0] AUTOMUTE_RESET = 2'h2;
    localparam logic [5:0] MARGIN_RESET = 6'h00;
    localparam logic [1:0] DETECT_METHOD_RESET = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OMR_DET_RISE = 2'b00,
        OMR_DET_BOTH = 2'b01,
        OMR_DET_FALL = 2'b10,
        OMR_DET_LEVEL = 2'b11
    } omr_detect_t;
endpackage : omr_pkg

// ===== verilog/omr_regs.sv
`timescale 1ns/1ps
module omr_regs #(
    parameter int DIV_W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clk_src_valid,
    input wire logic first_status_pin_is_clock,
    input wire logic second_status_pin_is_clock,
    input wire logic [6*DIV_W-1:0] divider_value,
    output logic first_status_pin_enable,
    output logic second_status_pin_enable,
    output logic [5:0] divider_margin_active,
    output logic [1:0] secondary_input_detect_method,
    output logic secondary_slew_rise_en,
    output logic secondary_slew_fall_en,
    output logic secondary_level_detect_en
);

    typedef struct packed {
        logic src_valid_m;
        logic src_valid_s;
        logic [1:0] automute;
        logic [5:0] margin;
        logic [1:0] detect;
        logic aw_have;
        logic [9:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic pin0_en;
        logic pin1_en;
        logic [5:0] margin_act;
        logic slew_rise;
        logic slew_fall;
        logic level_det;
    } omr_state_t;

    omr_state_t s_q;
    omr_state_t s_d;
    logic [5:0] div_above;

    // Divider range check per divider
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_div
            assign div_above[gi] = divider_value[gi*DIV_W +: DIV_W] >
                DIV_W'(omr_pkg::DIVIDE_MARGIN_MIN);
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        s_d.src_valid_m = clk_src_valid;
        s_d.src_valid_s = s_q.src_valid_m;
        // Write channel capture
        if (s_axi_awvalid && !s_q.aw_have) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_have) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = omr_pkg::RESP_OKAY;
            if (s_q.aw_addr == omr_pkg::STATUS_PIN_MUTE_CTRL_ADDR) begin
                if (s_q.w_strb[0]) begin
                    s_d.automute = s_q.w_data[1:0];
                end
            end else if (s_q.aw_addr == omr_pkg::DIVIDER_DYNAMIC_DELAY_CTRL_ADDR) begin
                if (s_q.w_strb[0]) begin
                    s_d.margin = s_q.w_data[5:0];
                end
            end else if (s_q.aw_addr == omr_pkg::REFERENCE_DETECT_CTRL_ADDR) begin
                if (s_q.w_strb[0]) begin
                    s_d.detect = s_q.w_data[omr_pkg::DETECT_METHOD_LSB +: 2];
                end
            end else if (s_q.aw_addr == omr_pkg::CLK_SRC_STATUS_ADDR) begin
                s_d.bresp = omr_pkg::RESP_OKAY;
            end else begin
                s_d.bresp = omr_pkg::RESP_SLVERR;
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Read channel
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = omr_pkg::RESP_OKAY;
            s_d.rdata = 32'h0000_0000;
            if (s_axi_araddr == omr_pkg::STATUS_PIN_MUTE_CTRL_ADDR) begin
                s_d.rdata[1:0] = s_q.automute;
            end else if (s_axi_araddr == omr_pkg::DIVIDER_DYNAMIC_DELAY_CTRL_ADDR) begin
                s_d.rdata[5:0] = s_q.margin;
            end else if (s_axi_araddr == omr_pkg::REFERENCE_DETECT_CTRL_ADDR) begin
                s_d.rdata[omr_pkg::DETECT_METHOD_LSB +: 2] = s_q.detect;
            end else if (s_axi_araddr == omr_pkg::CLK_SRC_STATUS_ADDR) begin
                s_d.rdata[0] = s_q.src_valid_s;
                s_d.rdata[1] = s_q.pin0_en;
                s_d.rdata[2] = s_q.pin1_en;
                s_d.rdata[13:8] = s_q.margin_act;
            end else begin
                s_d.rresp = omr_pkg::RESP_SLVERR;
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        // Status pin gating
        s_d.pin0_en = !first_status_pin_is_clock || !s_q.automute[omr_pkg::FIRST_AUTOMUTE_BIT]
            || s_q.src_valid_s;
        s_d.pin1_en = !second_status_pin_is_clock || !s_q.automute[omr_pkg::SECOND_AUTOMUTE_BIT]
            || s_q.src_valid_s;
        s_d.margin_act = s_q.margin & div_above;
        // Detector selection
        s_d.slew_rise = 1'b0;
        s_d.slew_fall = 1'b0;
        s_d.level_det = 1'b0;
        case (omr_pkg::omr_detect_t'(s_q.detect))
            omr_pkg::OMR_DET_RISE: begin
                s_d.slew_rise = 1'b1;
            end
            omr_pkg::OMR_DET_BOTH: begin
                s_d.slew_rise = 1'b1;
                s_d.slew_fall = 1'b1;
            end
            omr_pkg::OMR_DET_FALL: begin
                s_d.slew_fall = 1'b1;
            end
            default: begin
                s_d.level_det = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.automute <= omr_pkg::AUTOMUTE_RESET;
            s_q.margin <= omr_pkg::MARGIN_RESET;
            s_q.detect <= omr_pkg::DETECT_METHOD_RESET;
            s_q.pin0_en <= 1'b1;
            s_q.pin1_en <= 1'b1;
            s_q.slew_rise <= 1'b1;
            s_q.slew_fall <= 1'b1;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = !s_q.aw_have;
    assign s_axi_wready = !s_q.w_have;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign first_status_pin_enable = s_q.pin0_en;
    assign second_status_pin_enable = s_q.pin1_en;
    assign divider_margin_active = s_q.margin_act;
    assign secondary_input_detect_method = s_q.detect;
    assign secondary_slew_rise_en = s_q.slew_rise;
    assign secondary_slew_fall_en = s_q.slew_fall;
    assign secondary_level_detect_en = s_q.level_det;

endmodule : omr_regs

// ===== test/omr_regs_asserts.sv
`timescale 1ns/1ps
module omr_regs_asserts #(parameter int DIV_W = 8) (
    input wire logic mclk, rst, clk_src_valid, first_status_pin_is_clock,
    input wire logic second_status_pin_is_clock, first_status_pin_enable,
    input wire logic second_status_pin_enable, secondary_slew_rise_en,
    input wire logic secondary_slew_fall_en, secondary_level_detect_en,
    input wire logic [6*DIV_W-1:0] divider_value,
    input wire logic [5:0] divider_margin_active,
    input wire logic [1:0] secondary_input_detect_method
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_p1_mute;
        !second_status_pin_enable |-> $past(second_status_pin_is_clock)
            && !($past(clk_src_valid, 2) && $past(clk_src_valid, 3) && $past(clk_src_valid, 4));
    endproperty
    a_p1_mute: assert property (p_p1_mute) else $error("pin1 muted without cause");
    property p_p1_run;
        $past(clk_src_valid, 2) && $past(clk_src_valid, 3) && $past(clk_src_valid, 4)
            |-> second_status_pin_enable;
    endproperty
    a_p1_run: assert property (p_p1_run) else $error("pin1 muted on valid source");
    property p_p1_noclk;
        !$past(second_status_pin_is_clock) |-> second_status_pin_enable;
    endproperty
    a_p1_noclk: assert property (p_p1_noclk) else $error("pin1 muted as non clock");
    property p_p0_mute;
        !first_status_pin_enable |-> $past(first_status_pin_is_clock) && !$past(clk_src_valid, 3);
    endproperty
    a_p0_mute: assert property (p_p0_mute) else $error("pin0 muted without cause");
    property p_p0_run;
        $past(clk_src_valid, 2) && $past(clk_src_valid, 3) && $past(clk_src_valid, 4)
            |-> first_status_pin_enable;
    endproperty
    a_p0_run: assert property (p_p0_run) else $error("pin0 muted on valid source");
    property p_margin(int i);
        divider_margin_active[i] |-> $past(divider_value[i*DIV_W+:DIV_W]) > 8;
    endproperty
    for (genvar i = 0; i < 6; i++) begin : g_m
        a_margin: assert property (p_margin(i)) else $error("margin on small divide");
    end
    property p_slew;
        secondary_slew_rise_en == ($past(secondary_input_detect_method) inside {2'h0, 2'h1})
            && secondary_slew_fall_en
            == ($past(secondary_input_detect_method) inside {2'h1, 2'h2});
    endproperty
    a_slew: assert property (p_slew) else $error("slew decode wrong");
    property p_level;
        secondary_level_detect_en == ($past(secondary_input_detect_method) == 2'h3);
    endproperty
    a_level: assert property (p_level) else $error("level decode wrong");
    c_mute: cover property (!second_status_pin_enable);
    c_margin: cover property (divider_margin_active[5]);
    c_level: cover property (secondary_level_detect_en);
endmodule : omr_regs_asserts
bind omr_regs omr_regs_asserts #(.DIV_W(DIV_W)) omr_regs_asserts_inst (.*);

// ===== test/tb_omr_regs.sv
`timescale 1ns/1ps
module tb_omr_regs;
    logic mclk = 0, rst = 1, ce = 1, clk_src_valid = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic first_status_pin_is_clock = 0, second_status_pin_is_clock = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, first_status_pin_enable, second_status_pin_enable;
    logic secondary_slew_rise_en, secondary_slew_fall_en, secondary_level_detect_en;
    logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, secondary_input_detect_method, rs;
    logic [47:0] divider_value = 0;
    logic [5:0] divider_margin_active, m;
    int err_total = 0, check_count = 0;
    omr_regs omr_regs_inst (.*);
    always #2 mclk = ~mclk;
    task give_verdict;
        $display("Checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task tmo(input int n);
        if (n >= 99) begin
            err_total++;
            give_verdict;
        end
    endtask : tmo
    task wr(input logic [9:0] a, input logic [31:0] v);
        int n;
        @(posedge mclk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (n = 0; n < 99; n++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp; s_axi_bready <= 0; tmo(n);
    endtask : wr
    task rd(input logic [9:0] a);
        int n;
        @(posedge mclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        for (n = 0; n < 99; n++) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0; tmo(n);
    endtask : rd
    function logic en(input logic c, input logic b, input logic v);
        return !(c && b && !v);
    endfunction : en
    function logic [5:0] mg(input logic [5:0] b, input logic [47:0] dv);
        for (int i = 0; i < 6; i++) mg[i] = b[i] && dv[i*8+:8] > 8;
    endfunction : mg
    initial begin
        void'($urandom(32'hb63f));
        repeat (8) @(posedge mclk);
        rst <= 0;
        rd(omr_pkg::STATUS_PIN_MUTE_CTRL_ADDR); chk("mute reset", 32'h2, d);
        rd(omr_pkg::DIVIDER_DYNAMIC_DELAY_CTRL_ADDR); chk("margin reset", 32'h0, d);
        rd(omr_pkg::REFERENCE_DETECT_CTRL_ADDR); chk("detect reset", 32'h40, d);
        for (int k = 0; k < 4; k++) begin
            wr(omr_pkg::REFERENCE_DETECT_CTRL_ADDR, k << 6);
            repeat (2) @(posedge mclk);
            chk("method", k, secondary_input_detect_method);
            chk("rise", k < 2, secondary_slew_rise_en);
            chk("fall", k == 1 || k == 2, secondary_slew_fall_en);
            chk("level", k == 3, secondary_level_detect_en);
        end
        for (int k = 0; k < 12; k++) begin
            m = $urandom;
            for (int j = 0; j < 6; j++) divider_value[j*8+:8] <= 8'($urandom_range(11, 6));
            wr(omr_pkg::DIVIDER_DYNAMIC_DELAY_CTRL_ADDR, m);
            repeat (2) @(posedge mclk);
            chk("margin", mg(m, divider_value), divider_margin_active);
            rd(omr_pkg::DIVIDER_DYNAMIC_DELAY_CTRL_ADDR); chk("margin rd", m, d);
        end
        for (int k = 0; k < 16; k++) begin
            m = k ? $urandom : 6'h0f;
            wr(omr_pkg::STATUS_PIN_MUTE_CTRL_ADDR, m[1:0]);
            first_status_pin_is_clock <= m[2];
            second_status_pin_is_clock <= m[3];
            clk_src_valid <= m[4];
            repeat (5) @(posedge mclk);
            chk("pin0", en(m[2], m[0], m[4]), first_status_pin_enable);
            chk("pin1", en(m[3], m[1], m[4]), second_status_pin_enable);
        end
        wr(10'h3fc, 32'h1); chk("bresp", omr_pkg::RESP_SLVERR, rs);
        rd(10'h3fc); chk("rresp", omr_pkg::RESP_SLVERR, rs);
        give_verdict;
    end
endmodule : tb_omr_regs
